// [ccu_pkg.sv]
// Constants shared by the compare/capture unit files
package ccu_pkg;

    // ------------------------------------------------------------
    // Sizes and timing
    // ------------------------------------------------------------
    localparam int CNT_W = 16;
    localparam int T2_CH = 5;
    localparam int GRP_CH = 8;
    localparam int CAP_CH = 4;
    localparam int MC_DIV = 6;
    localparam int PRESC_W = 8;
    localparam logic [3:0] PRESC_MAX = 4'h8;
    localparam int IRQ_W = 4;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PRESC = 8'h01;
    localparam logic [7:0] ADDR_STATUS = 8'h02;
    localparam logic [7:0] ADDR_MASK = 8'h03;
    localparam logic [7:0] ADDR_T2_COUNT = 8'h04;
    localparam logic [7:0] ADDR_T2_CMP = 8'h06;
    localparam logic [7:0] ADDR_T2_EN = 8'h10;
    localparam logic [7:0] ADDR_T2_MODE1 = 8'h11;
    localparam logic [7:0] ADDR_T2_CAPT = 8'h12;
    localparam logic [7:0] ADDR_P1_LATCH = 8'h13;
    localparam logic [7:0] ADDR_P5_LATCH = 8'h14;
    localparam logic [7:0] ADDR_GRP_CMP = 8'h20;
    localparam logic [7:0] ADDR_GRP_EN = 8'h30;
    localparam logic [7:0] ADDR_GRP_SEL = 8'h31;
    localparam logic [7:0] ADDR_GRP_REL = 8'h32;
    localparam logic [7:0] ADDR_GRP_LATCH = 8'h34;
    localparam logic [7:0] ADDR_CT_COUNT = 8'h36;

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    localparam int CTRL_T2_MODE_LSB = 0;
    localparam int CTRL_RELOAD_EN = 2;
    localparam int CTRL_RELOAD_TRIG = 3;
    localparam int CTRL_CT_RUN = 4;
    localparam int CTRL_CT1_RUN = 5;
    localparam int CTRL_REMAP = 6;
    localparam int CTRL_T2_HALF = 7;
    localparam int MODE1_CONCURRENT = 5;
    localparam logic [1:0] T2_STOP = 2'h0;
    localparam logic [1:0] T2_TIMER = 2'h1;
    localparam logic [1:0] T2_GATED = 2'h2;
    localparam logic [1:0] T2_COUNTER = 2'h3;

    // ------------------------------------------------------------
    // Interrupt status bits
    // ------------------------------------------------------------
    localparam int ST_T2 = 0;
    localparam int ST_CT = 1;
    localparam int ST_CT1 = 2;
    localparam int ST_CONC = 3;

endpackage : ccu_pkg

// [ccu_properties.sv]
// Port-level properties of the compare/capture unit
module ccu_properties (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic [ccu_pkg::T2_CH-1:0] timer2_compare_o,
    input wire logic [ccu_pkg::GRP_CH-1:0] assignable_compare_o,
    input wire logic [ccu_pkg::GRP_CH-1:0] concurrent_output_o,
    input wire logic [ccu_pkg::GRP_CH-1:0] second_group_compare_o,
    input wire logic irq_o
);
    // ------------------------------------------------------------
    // Shadows of low registers, quiet counters
    // ------------------------------------------------------------
    logic [7:0] sh_reg [32];
    logic [2:0] idle_reg;
    logic [2:0] stop_reg;
    logic wr_p1;
    assign wr_p1 = wr_i && addr_i == ccu_pkg::ADDR_P1_LATCH;
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sh_reg <= '{default: 8'h00};
            idle_reg <= 3'h0;
            stop_reg <= 3'h0;
        end
        else
        begin
            if (wr_i && addr_i < 8'h20)
                sh_reg[addr_i[4:0]] <= wdata_i;
            idle_reg <= (sh_reg[0][5:0] != 6'h00 || wr_i) ? 3'h0
                : idle_reg + 3'(idle_reg != 3'h7);
            stop_reg <= (sh_reg[0][2:0] != 3'h0) ? 3'h0
                : stop_reg + 3'(stop_reg != 3'h7);
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    property p_rd_slot;
        !$past(rd_i) |-> rdata_o == 8'h00;
    endproperty
    a_rd_slot: assert property (p_rd_slot) else $error("stray rdata");
    property p_t2_hold;
        idle_reg > 3'h3 |-> $stable(timer2_compare_o);
    endproperty
    a_t2_hold: assert property (p_t2_hold) else $error("t2 moved");
    property p_asg_hold;
        idle_reg > 3'h3 |-> $stable(assignable_compare_o);
    endproperty
    a_asg_hold: assert property (p_asg_hold) else $error("asg moved");
    property p_grp_hold;
        idle_reg > 3'h3 |-> $stable(second_group_compare_o);
    endproperty
    a_grp_hold: assert property (p_grp_hold) else $error("grp moved");
    property p_conc_hold;
        idle_reg > 3'h3 |-> $stable(concurrent_output_o);
    endproperty
    a_conc_hold: assert property (p_conc_hold) else $error("conc moved");
    property p_irq_mask;
        sh_reg[3][3:0] == 4'h0 |-> !irq_o;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq masked");
    property p_latch_free;
        wr_p1 && !sh_reg[16][0] |=> timer2_compare_o[0] == $past(wdata_i[0]);
    endproperty
    a_latch_free: assert property (p_latch_free) else $error("latch");
    property p_mode0_lock;
        stop_reg > 3'h3 && wr_p1 && sh_reg[16][1] && !sh_reg[17][1]
            && !sh_reg[18][0] |=> $stable(timer2_compare_o[1]) [*2];
    endproperty
    a_mode0_lock: assert property (p_mode0_lock) else $error("mode0");
endmodule : ccu_properties

bind compare_capture_unit ccu_properties ccu_properties_i (.clk_i,
    .arst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .timer2_compare_o, .assignable_compare_o, .concurrent_output_o,
    .second_group_compare_o, .irq_o);

// [compare_capture_unit.sv]
// Compare/capture unit: timer 2, compare timer, compare timer 1
//
// Notes on behaviour
// - Reload/compare and four timer 2 registers compare against timer 2 only.
// - Each assignable register picks timer 2 (mode 0) or compare timer (mode 1).
// - Second group and its reload belong to compare timer 1; mode 0 or capture.
// - Reload/compare: modes 0, 1, reload; four others: modes 0, 1, capture.
// - Fourth timer 2 register can drive all eight concurrent outputs on match.
// - Gated mode counts only while gate pin high, sampled each machine cycle.
// - Counter mode counts falling edges sampled each machine cycle.
// - Reload mode 0: rollover sets overflow flag and loads reload value.
// - Reload mode 1: falling edge on trigger pin loads reload value.
// - Compare timers use prescaler from oscillator rate down to divide by 256.
// - Started compare timers run freely, reloading on overflow.
// - Compare timer rollover sets that timer's interrupt flag.
// - Enabled pairings compare value with count and act on equality.
// - Mode 0 output goes high on match, low on timer overflow.
// - Mode 0 pins ignore port latch writes.
// - Remap select chooses which group the shared offsets reach.
module compare_capture_unit (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic timer2_gate_count_pin_i,
    input wire logic timer2_reload_trigger_pin_i,
    input wire logic [ccu_pkg::CAP_CH-1:0] timer2_capture_pins_i,
    input wire logic [ccu_pkg::GRP_CH-1:0] second_group_capture_pins_i,
    output logic [ccu_pkg::T2_CH-1:0] timer2_compare_o,
    output logic [ccu_pkg::GRP_CH-1:0] assignable_compare_o,
    output logic [ccu_pkg::GRP_CH-1:0] concurrent_output_o,
    output logic [ccu_pkg::GRP_CH-1:0] second_group_compare_o,
    output logic irq_o
);

    localparam int W = ccu_pkg::CNT_W;
    localparam int T2N = ccu_pkg::T2_CH;
    localparam int GN = ccu_pkg::GRP_CH;
    localparam logic [2:0] MC_LAST = 3'(ccu_pkg::MC_DIV - 1);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] mc_cnt;
        logic mc_half;
        logic gate_smp;
        logic cnt_smp;
        logic trig_prev;
        logic [ccu_pkg::PRESC_W-1:0] presc;
        logic [7:0] ctrl;
        logic [7:0] presc_sel;
        logic [ccu_pkg::IRQ_W-1:0] status;
        logic [ccu_pkg::IRQ_W-1:0] mask;
        logic [T2N-1:0][W-1:0] t2_val;
        logic [T2N-1:0] t2_en;
        logic [7:0] t2_mode1;
        logic [ccu_pkg::CAP_CH-1:0] t2_capt;
        logic [1:0][GN-1:0][W-1:0] grp_val;
        logic [1:0][GN-1:0] grp_en;
        logic [1:0][GN-1:0] grp_sel;
        logic [1:0][W-1:0] grp_rel;
        logic [ccu_pkg::CAP_CH-1:0] t2cap_prev;
        logic [GN-1:0] grpcap_prev;
        logic [7:0] rdata;
    } ccu_state_s;

    ccu_state_s state_reg;
    ccu_state_s state_next;

    logic mc_en;
    logic t2_tick;
    logic t2_load;
    logic [W-1:0] t2_rel;
    logic ct_tick;
    logic ct1_tick;
    logic rm;
    logic [W-1:0] t2_count;
    logic [W-1:0] ct_count;
    logic [W-1:0] ct1_count;
    logic t2_step;
    logic t2_ovf;
    logic ct_step;
    logic ct_ovf;
    logic ct1_step;
    logic ct1_ovf;
    logic [T2N-1:0] t2_match;
    logic [T2N-1:0] t2_capt_all;
    logic [7:0] rd_val;
    logic [ccu_pkg::IRQ_W-1:0] irq_set;

    function automatic logic [7:0] presc_mask(input logic [3:0] sel);
        logic [3:0] n;
        n = (sel > ccu_pkg::PRESC_MAX) ? ccu_pkg::PRESC_MAX : sel;
        presc_mask = 8'((9'h001 << n) - 9'h001);
    endfunction : presc_mask

    // ------------------------------------------------------------
    // Clock enables and timer inputs
    // ------------------------------------------------------------
    assign mc_en = (state_reg.mc_cnt == MC_LAST);
    assign rm = state_reg.ctrl[ccu_pkg::CTRL_REMAP];

    always_comb
    begin
        case (state_reg.ctrl[ccu_pkg::CTRL_T2_MODE_LSB +: 2])
            ccu_pkg::T2_TIMER:
                t2_tick = mc_en & (!state_reg.ctrl[ccu_pkg::CTRL_T2_HALF]
                    | state_reg.mc_half);
            ccu_pkg::T2_GATED:
                t2_tick = mc_en & state_reg.gate_smp;
            ccu_pkg::T2_COUNTER:
                t2_tick = mc_en & state_reg.cnt_smp
                    & !timer2_gate_count_pin_i;
            default:
                t2_tick = 1'b0;
        endcase
    end

    // Trigger reload only in reload mode 1
    assign t2_load = state_reg.ctrl[ccu_pkg::CTRL_RELOAD_EN]
        & state_reg.ctrl[ccu_pkg::CTRL_RELOAD_TRIG]
        & state_reg.trig_prev & !timer2_reload_trigger_pin_i;
    assign t2_rel = (state_reg.ctrl[ccu_pkg::CTRL_RELOAD_EN]
        & !state_reg.ctrl[ccu_pkg::CTRL_RELOAD_TRIG])
        ? state_reg.t2_val[0] : '0;

    assign ct_tick = state_reg.ctrl[ccu_pkg::CTRL_CT_RUN]
        & ((state_reg.presc & presc_mask(state_reg.presc_sel[3:0])) == '0);
    assign ct1_tick = state_reg.ctrl[ccu_pkg::CTRL_CT1_RUN]
        & ((state_reg.presc & presc_mask(state_reg.presc_sel[7:4])) == '0);

    // ------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------
    count_timer #(.W(W)) u_timer2 (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .tick_i(t2_tick),
        .load_i(t2_load),
        .load_val_i(state_reg.t2_val[0]),
        .reload_val_i(t2_rel),
        .count_o(t2_count),
        .step_o(t2_step),
        .ovf_o(t2_ovf)
    );

    count_timer #(.W(W)) u_compare_timer (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .tick_i(ct_tick),
        .load_i(1'b0),
        .load_val_i(state_reg.grp_rel[0]),
        .reload_val_i(state_reg.grp_rel[0]),
        .count_o(ct_count),
        .step_o(ct_step),
        .ovf_o(ct_ovf)
    );

    count_timer #(.W(W)) u_second_compare_timer (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .tick_i(ct1_tick),
        .load_i(1'b0),
        .load_val_i(state_reg.grp_rel[1]),
        .reload_val_i(state_reg.grp_rel[1]),
        .count_o(ct1_count),
        .step_o(ct1_step),
        .ovf_o(ct1_ovf)
    );

    // ------------------------------------------------------------
    // Compare outputs
    // ------------------------------------------------------------
    assign t2_capt_all = {state_reg.t2_capt, 1'b0};

    genvar gi;
    generate
        for (gi = 0; gi < T2N; gi++)
        begin : g_t2
            assign t2_match[gi] = t2_step
                & (t2_count == state_reg.t2_val[gi]);
            compare_output_latch u_latch (
                .clk_i(clk_i),
                .arst_n_i(arst_n_i),
                .en_i(state_reg.t2_en[gi] & !t2_capt_all[gi]),
                .mode1_i(state_reg.t2_mode1[gi]),
                .match_i(t2_match[gi]),
                .ovf_i(t2_ovf),
                .wr_i(wr_i & (addr_i == ccu_pkg::ADDR_P1_LATCH)),
                .wbit_i(wdata_i[gi]),
                .pin_o(timer2_compare_o[gi])
            );
        end
        for (gi = 0; gi < GN; gi++)
        begin : g_grp
            logic sel;
            assign sel = state_reg.grp_sel[0][gi];
            compare_output_latch u_assign (
                .clk_i(clk_i),
                .arst_n_i(arst_n_i),
                .en_i(state_reg.grp_en[0][gi]),
                .mode1_i(sel),
                .match_i(sel
                    ? ct_step & (ct_count == state_reg.grp_val[0][gi])
                    : t2_step & (t2_count == state_reg.grp_val[0][gi])),
                .ovf_i(sel ? ct_ovf : t2_ovf),
                .wr_i(wr_i & !rm & (addr_i == ccu_pkg::ADDR_GRP_LATCH)),
                .wbit_i(wdata_i[gi]),
                .pin_o(assignable_compare_o[gi])
            );
            compare_output_latch u_concurrent (
                .clk_i(clk_i),
                .arst_n_i(arst_n_i),
                .en_i(state_reg.t2_mode1[ccu_pkg::MODE1_CONCURRENT]),
                .mode1_i(1'b1),
                .match_i(t2_match[T2N-1]),
                .ovf_i(1'b0),
                .wr_i(wr_i & (addr_i == ccu_pkg::ADDR_P5_LATCH)),
                .wbit_i(wdata_i[gi]),
                .pin_o(concurrent_output_o[gi])
            );
            compare_output_latch u_second (
                .clk_i(clk_i),
                .arst_n_i(arst_n_i),
                .en_i(state_reg.grp_en[1][gi]
                    & !state_reg.grp_sel[1][gi]),
                .mode1_i(1'b0),
                .match_i(ct1_step
                    & (ct1_count == state_reg.grp_val[1][gi])),
                .ovf_i(ct1_ovf),
                .wr_i(wr_i & rm & (addr_i == ccu_pkg::ADDR_GRP_LATCH)),
                .wbit_i(wdata_i[gi]),
                .pin_o(second_group_compare_o[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb
    begin
        rd_val = '0;
        case (addr_i)
            ccu_pkg::ADDR_CTRL: rd_val = state_reg.ctrl;
            ccu_pkg::ADDR_PRESC: rd_val = state_reg.presc_sel;
            ccu_pkg::ADDR_STATUS: rd_val = 8'(state_reg.status);
            ccu_pkg::ADDR_MASK: rd_val = 8'(state_reg.mask);
            ccu_pkg::ADDR_T2_COUNT: rd_val = t2_count[7:0];
            ccu_pkg::ADDR_T2_COUNT + 8'h01: rd_val = t2_count[15:8];
            ccu_pkg::ADDR_T2_EN: rd_val = 8'(state_reg.t2_en);
            ccu_pkg::ADDR_T2_MODE1: rd_val = state_reg.t2_mode1;
            ccu_pkg::ADDR_T2_CAPT: rd_val = 8'(state_reg.t2_capt);
            ccu_pkg::ADDR_P1_LATCH: rd_val = 8'(timer2_compare_o);
            ccu_pkg::ADDR_P5_LATCH: rd_val = concurrent_output_o;
            ccu_pkg::ADDR_GRP_EN: rd_val = state_reg.grp_en[rm];
            ccu_pkg::ADDR_GRP_SEL: rd_val = state_reg.grp_sel[rm];
            ccu_pkg::ADDR_GRP_REL: rd_val = state_reg.grp_rel[rm][7:0];
            ccu_pkg::ADDR_GRP_REL + 8'h01:
                rd_val = state_reg.grp_rel[rm][15:8];
            ccu_pkg::ADDR_GRP_LATCH:
                rd_val = rm ? second_group_compare_o : assignable_compare_o;
            ccu_pkg::ADDR_CT_COUNT:
                rd_val = rm ? ct1_count[7:0] : ct_count[7:0];
            ccu_pkg::ADDR_CT_COUNT + 8'h01:
                rd_val = rm ? ct1_count[15:8] : ct_count[15:8];
            default: rd_val = '0;
        endcase
        for (int i = 0; i < T2N; i++)
        begin
            if (addr_i == 8'(ccu_pkg::ADDR_T2_CMP + 2 * i))
                rd_val = state_reg.t2_val[i][7:0];
            if (addr_i == 8'(ccu_pkg::ADDR_T2_CMP + 2 * i + 1))
                rd_val = state_reg.t2_val[i][15:8];
        end
        for (int k = 0; k < GN; k++)
        begin
            if (addr_i == 8'(ccu_pkg::ADDR_GRP_CMP + 2 * k))
                rd_val = state_reg.grp_val[rm][k][7:0];
            if (addr_i == 8'(ccu_pkg::ADDR_GRP_CMP + 2 * k + 1))
                rd_val = state_reg.grp_val[rm][k][15:8];
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        irq_set = '0;
        irq_set[ccu_pkg::ST_T2] = t2_ovf;
        irq_set[ccu_pkg::ST_CT] = ct_ovf;
        irq_set[ccu_pkg::ST_CT1] = ct1_ovf;
        irq_set[ccu_pkg::ST_CONC] = t2_match[T2N-1]
            & state_reg.t2_mode1[ccu_pkg::MODE1_CONCURRENT];

        state_next = state_reg;
        state_next.mc_cnt = mc_en ? '0 : state_reg.mc_cnt + 3'h1;
        state_next.presc = state_reg.presc + 1'b1;
        state_next.trig_prev = timer2_reload_trigger_pin_i;
        state_next.t2cap_prev = timer2_capture_pins_i;
        state_next.grpcap_prev = second_group_capture_pins_i;
        state_next.rdata = rd_i ? rd_val : '0;
        if (mc_en)
        begin
            state_next.mc_half = !state_reg.mc_half;
            state_next.gate_smp = timer2_gate_count_pin_i;
            state_next.cnt_smp = timer2_gate_count_pin_i;
        end

        // Register writes
        if (wr_i)
        begin
            case (addr_i)
                ccu_pkg::ADDR_CTRL: state_next.ctrl = wdata_i;
                ccu_pkg::ADDR_PRESC: state_next.presc_sel = wdata_i;
                ccu_pkg::ADDR_MASK:
                    state_next.mask = wdata_i[ccu_pkg::IRQ_W-1:0];
                ccu_pkg::ADDR_T2_EN:
                    state_next.t2_en = wdata_i[T2N-1:0];
                ccu_pkg::ADDR_T2_MODE1: state_next.t2_mode1 = wdata_i;
                ccu_pkg::ADDR_T2_CAPT:
                    state_next.t2_capt = wdata_i[ccu_pkg::CAP_CH-1:0];
                ccu_pkg::ADDR_GRP_EN: state_next.grp_en[rm] = wdata_i;
                ccu_pkg::ADDR_GRP_SEL: state_next.grp_sel[rm] = wdata_i;
                ccu_pkg::ADDR_GRP_REL:
                    state_next.grp_rel[rm][7:0] = wdata_i;
                ccu_pkg::ADDR_GRP_REL + 8'h01:
                    state_next.grp_rel[rm][15:8] = wdata_i;
                default: ;
            endcase
            for (int i = 0; i < T2N; i++)
            begin
                if (addr_i == 8'(ccu_pkg::ADDR_T2_CMP + 2 * i))
                    state_next.t2_val[i][7:0] = wdata_i;
                if (addr_i == 8'(ccu_pkg::ADDR_T2_CMP + 2 * i + 1))
                    state_next.t2_val[i][15:8] = wdata_i;
            end
            for (int k = 0; k < GN; k++)
            begin
                if (addr_i == 8'(ccu_pkg::ADDR_GRP_CMP + 2 * k))
                    state_next.grp_val[rm][k][7:0] = wdata_i;
                if (addr_i == 8'(ccu_pkg::ADDR_GRP_CMP + 2 * k + 1))
                    state_next.grp_val[rm][k][15:8] = wdata_i;
            end
        end

        // Captures win over a write in the same cycle
        for (int i = 0; i < ccu_pkg::CAP_CH; i++)
        begin
            if (state_reg.t2_capt[i] & timer2_capture_pins_i[i]
                & !state_reg.t2cap_prev[i])
                state_next.t2_val[i + 1] = t2_count;
        end
        for (int k = 0; k < GN; k++)
        begin
            if (state_reg.grp_sel[1][k] & second_group_capture_pins_i[k]
                & !state_reg.grpcap_prev[k])
                state_next.grp_val[1][k] = ct1_count;
        end

        // Sticky status: set wins over clear
        state_next.status = state_reg.status | irq_set;
        if (wr_i && addr_i == ccu_pkg::ADDR_STATUS)
            state_next.status = (state_reg.status
                & ~wdata_i[ccu_pkg::IRQ_W-1:0]) | irq_set;
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign rdata_o = state_reg.rdata;
    assign irq_o = |(state_reg.status & state_reg.mask);

endmodule : compare_capture_unit

// [compare_output_latch.sv]
// Port latch of one compare output with shadow latch
module compare_output_latch (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic en_i,
    input wire logic mode1_i,
    input wire logic match_i,
    input wire logic ovf_i,
    input wire logic wr_i,
    input wire logic wbit_i,
    output logic pin_o
);

    typedef struct packed {
        logic pin;
        logic shadow;
    } latch_state_s;

    latch_state_s state_reg;
    latch_state_s state_next;

    always_comb
    begin
        state_next = state_reg;
        if (!en_i)
        begin
            if (wr_i)
            begin
                state_next.pin = wbit_i;
                state_next.shadow = wbit_i;
            end
        end
        else if (mode1_i)
        begin
            if (wr_i)
                state_next.shadow = wbit_i;
            if (match_i)
                state_next.pin = state_next.shadow;
        end
        else
        begin
            // Port writes are ignored here
            if (ovf_i)
                state_next.pin = 1'b0;
            else if (match_i)
                state_next.pin = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign pin_o = state_reg.pin;

endmodule : compare_output_latch

// [count_timer.sv]
// Free-running up counter with overflow reload and external load
module count_timer #(
    parameter int W = 16
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic tick_i,
    input wire logic load_i,
    input wire logic [W-1:0] load_val_i,
    input wire logic [W-1:0] reload_val_i,
    output logic [W-1:0] count_o,
    output logic step_o,
    output logic ovf_o
);

    typedef struct packed {
        logic [W-1:0] count;
        logic step;
        logic ovf;
    } timer_state_s;

    timer_state_s state_reg;
    timer_state_s state_next;

    always_comb
    begin
        state_next = state_reg;
        state_next.step = 1'b0;
        state_next.ovf = 1'b0;
        if (load_i)
        begin
            state_next.count = load_val_i;
            state_next.step = 1'b1;
        end
        else if (tick_i)
        begin
            state_next.step = 1'b1;
            if (&state_reg.count)
            begin
                state_next.count = reload_val_i;
                state_next.ovf = 1'b1;
            end
            else
            begin
                state_next.count = state_reg.count + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign count_o = state_reg.count;
    assign step_o = state_reg.step;
    assign ovf_o = state_reg.ovf;

endmodule : count_timer

// [tb.sv]
// Self-checking bench of the compare/capture unit
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic gate_i = 1'b0;
    logic trig_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic [3:0] cap_i = 4'h0;
    logic [7:0] grp_cap_i = 8'h00;
    logic [7:0] rdata_o, asg_o, conc_o, grp_o;
    logic [4:0] t2_o;
    logic irq_o;
    int miscompares = 0;
    int n_compared = 0;
    int cnt, p5, conc, d;
    int q[$];
    always #50 clk_i = ~clk_i;
    compare_capture_unit compare_capture_unit_i (.clk_i, .arst_n_i,
        .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .timer2_gate_count_pin_i(gate_i), .timer2_reload_trigger_pin_i(trig_i),
        .timer2_capture_pins_i(cap_i), .second_group_capture_pins_i(grp_cap_i),
        .timer2_compare_o(t2_o), .assignable_compare_o(asg_o),
        .concurrent_output_o(conc_o), .second_group_compare_o(grp_o), .irq_o);
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input int v);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= v[7:0];
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        chk(rdata_o, exp);
    endtask : chk_reg
    // One falling edge on the count pin, model follows
    task automatic ev;
        gate_i <= 1'b1;
        repeat (12) @(posedge clk_i);
        gate_i <= 1'b0;
        repeat (12) @(posedge clk_i);
        cnt = (cnt == 16'hFFFF) ? 16'hFFFC : cnt + 1;
        if (cnt == 16'hFFFE)
            conc = p5;
    endtask : ev
    initial
    begin
        #8_000_000;
        miscompares++;
        give_verdict();
    end
    initial
    begin
        d = $urandom(63);
        repeat (16) @(posedge clk_i);
        arst_n_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk_reg(8'h00, 8'h00);
        for (int b = 0; b < 4; b++)
        begin
            wr(8'h00, b[0] ? 8'h40 : 8'h00);
            for (int a = 8'h20; a < 8'h30; a++)
            begin
                d = $urandom % 255 + 1;
                if (b < 2)
                    q.push_back(d);
                if (b < 2)
                    wr(a[7:0], d);
                else
                    chk_reg(a[7:0], q.pop_front());
            end
        end
        chk_reg(8'hFF, 8'h00);
        p5 = $urandom & 255;
        wr(8'h06, 8'hFC);
        wr(8'h07, 8'hFF);
        wr(8'h08, 8'hFD);
        wr(8'h09, 8'hFF);
        wr(8'h0E, 8'hFE);
        wr(8'h0F, 8'hFF);
        wr(8'h14, p5);
        wr(8'h10, 8'h02);
        wr(8'h11, 8'h20);
        wr(8'h03, 8'h01);
        wr(8'h13, 8'h1D);
        wr(8'h00, 8'h0F);
        trig_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk_reg(8'h04, 8'hFC);
        chk_reg(8'h05, 8'hFF);
        wr(8'h00, 8'h07);
        cnt = 16'hFFFC;
        for (int i = 0; i < 9; i++)
        begin
            ev();
            if (i == 4)
                p5 = $urandom & 255;
            if (i == 4)
                wr(8'h14, p5);
            chk(t2_o, {3'b111, cnt != 16'hFFFC, 1'b1});
            if (i > 0)
                chk(conc_o, conc);
        end
        chk_reg(8'h04, cnt[7:0]);
        chk(irq_o, 1'b1);
        chk_reg(8'h02, 8'h09);
        wr(8'h02, 8'h09);
        chk_reg(8'h02, 8'h00);
        chk(irq_o, 1'b0);
        wr(8'h00, 8'h00);
        repeat (6) @(posedge clk_i);
        wr(8'h13, 8'h00);
        repeat (3) @(posedge clk_i);
        chk(t2_o, {3'b000, cnt != 16'hFFFC, 1'b0});
        wr(8'h00, 8'h40);
        wr(8'h34, p5);
        wr(8'h32, 8'hF0);
        wr(8'h33, 8'hFF);
        wr(8'h00, 8'h00);
        wr(8'h32, 8'hF0);
        wr(8'h33, 8'hFF);
        wr(8'h30, 8'hFF);
        wr(8'h31, 8'hFF);
        wr(8'h34, 8'hFF);
        wr(8'h00, 8'h30);
        repeat (65600) @(posedge clk_i);
        chk_reg(8'h02, 8'h06);
        chk_reg(8'h37, 8'hFF);
        chk(asg_o, 8'hFF);
        chk(grp_o, p5);
        give_verdict();
    end
endmodule : tb
